// ===== rtl/mcsr_core_regs.sv
// core special registers: accumulator, aux, status word, stack pointer, data pointers
//
// Behaviour
// - 8-bit accumulator at 0xE0, reset 0x00, operand source and result
// - 8-bit aux register at 0xF0, reset 0x00, multiply/divide and scratch
// - status bit 7 is carry and Boolean accumulator
// - status bit 6 set on carry from accumulator bit 3 into 4
// - status bits 4-3 choose one of four register banks
// - status bit 2 set on signed overflow
// - status bit 0 always shows odd parity of accumulator
// - software writes to the status word never change the parity bit
// - status bits 5 and 1 are free user flags; status at 0xD0 resets 0x00
// - stack pointer at 0x81, reset 0x07, incremented before push or call
// - stack pointer decremented after pop or return
// - data pointers readable as 16 bits or two bytes; first at 0x82/0x83
// - high byte gives address bits 15:8, low byte bits 7:0
// - second data pointer at 0x84/0x85
// - select register 0x92 bit 0 picks the active pointer; bits 7:1 unused
// - indirect 16-bit address comes from the selected pointer
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module mcsr_core_regs
	import mcsr_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// software register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// datapath results
	input wire logic acc_load,
	input wire logic [7:0] acc_value,
	// aux register load
	input wire logic aux_load,
	input wire logic [7:0] aux_value,
	// flag updates
	input wire logic carry_load,
	input wire logic carry_value,
	input wire logic half_carry_load,
	input wire logic half_carry_value,
	input wire logic overflow_load,
	input wire logic overflow_value,
	// stack moves
	input wire logic stack_push,
	input wire logic stack_pop,
	// active data pointer load and step
	input wire logic dptr_load,
	input wire logic [15:0] dptr_value,
	input wire logic dptr_inc,
	// values seen by the datapath
	output logic [7:0] accumulator,
	output logic [7:0] aux_operand,
	// status word with live parity
	output logic [7:0] status_word,
	// stack addresses and register bank base
	output logic [7:0] stack_top_pointer,
	output logic [7:0] stack_write_addr,
	output logic [4:0] bank_base,
	// indirect address source
	output logic [15:0] dptr_active,
	output logic pointer_select
);
	import mcsr_pkg::*;

	logic [7:0] acc_r;
	logic [7:0] aux_r;
	logic carry_r;
	logic half_r;
	logic ufa_r;
	logic [1:0] bank_r;
	logic ovf_r;
	logic ufb_r;
	logic [7:0] sp_r;
	logic [7:0] sp_nxt;
	logic [15:0] dp_r [2];
	logic psel_r;
	logic parity_nxt;
	logic [7:0] acc_nxt;
	logic [7:0] status_nxt;
	logic [7:0] rdata_nxt;

	// next values of the stored status fields
	logic carry_nxt;
	logic half_nxt;
	logic ufa_nxt;
	logic [1:0] bank_nxt;
	logic ovf_nxt;
	logic ufb_nxt;

	// software write decode, one strobe per register except the data pointer bytes
	logic wr_acc;
	logic wr_aux;
	logic wr_status;
	logic wr_stack;
	logic wr_psel;

	// decode shared by every process that takes a software write, except the data pointers, which decode their own
	assign wr_acc = reg_wr && (reg_addr == MCSR_OFF_ACC);
	assign wr_aux = reg_wr && (reg_addr == MCSR_OFF_AUX);
	assign wr_status = reg_wr && (reg_addr == MCSR_OFF_STATUS);
	assign wr_stack = reg_wr && (reg_addr == MCSR_OFF_STACK);
	assign wr_psel = reg_wr && (reg_addr == MCSR_OFF_PSEL);

	// datapath wins over a software write in the same cycle; core owns the order
	always_comb begin
		acc_nxt = acc_r;
		if (wr_acc) begin
			acc_nxt = reg_wdata;
		end
		if (acc_load) begin
			acc_nxt = acc_value;
		end
	end

	// parity follows the next accumulator so the flag output is never a cycle stale
	assign parity_nxt = ^acc_nxt;

	// accumulator
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			acc_r <= MCSR_RST_ZERO;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	// aux operand register
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			aux_r <= MCSR_RST_ZERO;
		end else if (aux_load) begin
			aux_r <= aux_value;
		end else if (wr_aux) begin
			aux_r <= reg_wdata;
		end
	end

	// next status fields; parity is not stored, software bit 0 is dropped
	// a hardware update beats a software write so no instruction result is lost
	always_comb begin
		carry_nxt = carry_r;
		half_nxt = half_r;
		ufa_nxt = ufa_r;
		bank_nxt = bank_r;
		ovf_nxt = ovf_r;
		ufb_nxt = ufb_r;
		if (wr_status) begin
			carry_nxt = reg_wdata[MCSR_BIT_CARRY];
			half_nxt = reg_wdata[MCSR_BIT_HALF];
			ufa_nxt = reg_wdata[MCSR_BIT_UFA];
			bank_nxt = reg_wdata[MCSR_BIT_BANK_HI:MCSR_BIT_BANK_LO];
			ovf_nxt = reg_wdata[MCSR_BIT_OVF];
			ufb_nxt = reg_wdata[MCSR_BIT_UFB];
		end
		if (carry_load) begin
			carry_nxt = carry_value;
		end
		if (half_carry_load) begin
			half_nxt = half_carry_value;
		end
		if (overflow_load) begin
			ovf_nxt = overflow_value;
		end
	end

	// carry flag
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			carry_r <= 1'b0;
		end else begin
			carry_r <= carry_nxt;
		end
	end

	// half carry flag
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			half_r <= 1'b0;
		end else begin
			half_r <= half_nxt;
		end
	end

	// first user flag
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ufa_r <= 1'b0;
		end else begin
			ufa_r <= ufa_nxt;
		end
	end

	// register bank select
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			bank_r <= 2'h0;
		end else begin
			bank_r <= bank_nxt;
		end
	end

	// overflow flag
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ovf_r <= 1'b0;
		end else begin
			ovf_r <= ovf_nxt;
		end
	end

	// second user flag
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ufb_r <= 1'b0;
		end else begin
			ufb_r <= ufb_nxt;
		end
	end

	// push pre-increments, pop post-decrements; both at once cancel
	always_comb begin
		sp_nxt = sp_r;
		if (wr_stack) begin
			sp_nxt = reg_wdata;
		end
		if (stack_push && !stack_pop) begin
			sp_nxt = sp_r + 8'h01;
		end else if (stack_pop && !stack_push) begin
			sp_nxt = sp_r - 8'h01;
		end
	end

	// stack pointer
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			sp_r <= MCSR_RST_STACK;
		end else begin
			sp_r <= sp_nxt;
		end
	end

	// two data pointers, byte-writable by software, word-loadable by the core
	generate
		for (genvar i = 0; i < 2; i++) begin : g_dp
			localparam logic [7:0] OFF_LO = (i == 0) ? MCSR_OFF_P0_LOW : MCSR_OFF_P1_LOW;
			localparam logic [7:0] OFF_HI = (i == 0) ? MCSR_OFF_P0_HIGH : MCSR_OFF_P1_HIGH;
			always_ff @(posedge core_clk) begin
				if (!reset_n) begin
					dp_r[i] <= {MCSR_RST_ZERO, MCSR_RST_ZERO};
				end else if (dptr_load && psel_r == i[0]) begin
					dp_r[i] <= dptr_value;
				end else if (dptr_inc && psel_r == i[0]) begin
					dp_r[i] <= dp_r[i] + 16'h0001;
				end else if (reg_wr && reg_addr == OFF_LO) begin
					dp_r[i][7:0] <= reg_wdata;
				end else if (reg_wr && reg_addr == OFF_HI) begin
					dp_r[i][15:8] <= reg_wdata;
				end
			end
		end
	endgenerate

	// pointer select; upper bits are not stored
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			psel_r <= 1'b0;
		end else if (wr_psel) begin
			psel_r <= reg_wdata[MCSR_BIT_PSEL];
		end
	end

	assign status_nxt = {carry_r, half_r, ufa_r, bank_r, ovf_r, ufb_r, 1'b0};

	// read multiplexer; parity is taken from the live accumulator, not stored
	always_comb begin
		rdata_nxt = MCSR_RST_ZERO;
		unique case (reg_addr)
			MCSR_OFF_ACC: rdata_nxt = acc_r;
			MCSR_OFF_AUX: rdata_nxt = aux_r;
			MCSR_OFF_STATUS: rdata_nxt = {status_nxt[7:1], ^acc_r};
			MCSR_OFF_STACK: rdata_nxt = sp_r;
			MCSR_OFF_P0_LOW: rdata_nxt = dp_r[0][7:0];
			MCSR_OFF_P0_HIGH: rdata_nxt = dp_r[0][15:8];
			MCSR_OFF_P1_LOW: rdata_nxt = dp_r[1][7:0];
			MCSR_OFF_P1_HIGH: rdata_nxt = dp_r[1][15:8];
			MCSR_OFF_PSEL: rdata_nxt = {7'h00, psel_r};
			default: rdata_nxt = MCSR_RST_ZERO;
		endcase
	end

	// read data, one cycle after the strobe; unmapped reads return zero
	// zero between reads keeps a stale byte from passing for a fresh answer
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			reg_rdata <= MCSR_RST_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= MCSR_RST_ZERO;
		end
	end

	// copies toward the core, except the active pointer and pointer select, are built from next values so they match the state
	// accumulator copy
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			accumulator <= MCSR_RST_ZERO;
		end else begin
			accumulator <= acc_nxt;
		end
	end

	// aux copy; same priority as the aux register itself
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			aux_operand <= MCSR_RST_ZERO;
		end else begin
			aux_operand <= aux_load ? aux_value : (wr_aux ? reg_wdata : aux_r);
		end
	end

	// stack top and the slot that the next push will fill
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			stack_top_pointer <= MCSR_RST_STACK;
			stack_write_addr <= MCSR_RST_STACK + 8'h01;
		end else begin
			stack_top_pointer <= sp_nxt;
			stack_write_addr <= sp_nxt + 8'h01;
		end
	end

	// status copy; parity comes from the next accumulator, never from a status write
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			status_word <= MCSR_RST_ZERO;
		end else begin
			status_word <= {carry_nxt, half_nxt, ufa_nxt, bank_nxt, ovf_nxt, ufb_nxt, parity_nxt};
		end
	end

	// register bank base: bank number times eight
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			bank_base <= 5'h00;
		end else begin
			bank_base <= {bank_nxt, 3'h0};
		end
	end

	// active pointer; registered, so it trails a select change by one cycle
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			dptr_active <= 16'h0000;
			pointer_select <= 1'b0;
		end else begin
			dptr_active <= psel_r ? dp_r[1] : dp_r[0];
			pointer_select <= psel_r;
		end
	end
endmodule

// ===== rtl/mcsr_pkg.sv
// package: offsets, reset values and field positions of the core special registers
package mcsr_pkg;
	localparam logic [7:0] MCSR_OFF_STACK = 8'h81;
	localparam logic [7:0] MCSR_OFF_P0_LOW = 8'h82;
	localparam logic [7:0] MCSR_OFF_P0_HIGH = 8'h83;
	localparam logic [7:0] MCSR_OFF_P1_LOW = 8'h84;
	localparam logic [7:0] MCSR_OFF_P1_HIGH = 8'h85;
	localparam logic [7:0] MCSR_OFF_PSEL = 8'h92;
	localparam logic [7:0] MCSR_OFF_STATUS = 8'hD0;
	localparam logic [7:0] MCSR_OFF_ACC = 8'hE0;
	localparam logic [7:0] MCSR_OFF_AUX = 8'hF0;
	localparam logic [7:0] MCSR_RST_STACK = 8'h07;
	localparam logic [7:0] MCSR_RST_ZERO = 8'h00;
	localparam int MCSR_BIT_CARRY = 7;
	localparam int MCSR_BIT_HALF = 6;
	localparam int MCSR_BIT_UFA = 5;
	localparam int MCSR_BIT_BANK_HI = 4;
	localparam int MCSR_BIT_BANK_LO = 3;
	localparam int MCSR_BIT_OVF = 2;
	localparam int MCSR_BIT_UFB = 1;
	localparam int MCSR_BIT_PARITY = 0;
	localparam int MCSR_BIT_PSEL = 0;
endpackage

// ===== tb/mcsr_core_regs_chk.sv
// checker: port relations of the core special registers
`timescale 1ns/1ps
module mcsr_core_regs_chk (
	// clock and reset
	input wire logic core_clk, reset_n,
	// core side
	input wire logic acc_load, carry_load, carry_value, half_carry_load, half_carry_value,
	input wire logic overflow_load, overflow_value,
	input wire logic stack_push, stack_pop,
	input wire logic [7:0] acc_value,
	// mirrored state
	input wire logic [7:0] accumulator, status_word, stack_top_pointer, stack_write_addr,
	input wire logic [4:0] bank_base
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// parity has no lag: it is read from the live accumulator
	a_parity_live: assert property (status_word[0] == ^accumulator)
		else $error("parity wrong");
	a_push_inc: assert property (stack_push && !stack_pop |=>
		stack_top_pointer == $past(stack_top_pointer) + 8'h01) else $error("push wrong");
	a_pop_dec: assert property (stack_pop && !stack_push |=>
		stack_top_pointer == $past(stack_top_pointer) - 8'h01) else $error("pop wrong");
	// a push writes one above the current top
	a_push_addr: assert property (stack_write_addr == stack_top_pointer + 8'h01)
		else $error("stack address wrong");
	a_bank_base: assert property (bank_base == {status_word[4:3], 3'b000})
		else $error("bank base wrong");
	a_acc_load: assert property (acc_load |=> accumulator == $past(acc_value))
		else $error("acc load wrong");
	a_carry_load: assert property (carry_load |=> status_word[7] == $past(carry_value))
		else $error("carry wrong");
	a_half_carry: assert property (half_carry_load |=>
		status_word[6] == $past(half_carry_value)) else $error("half carry wrong");
	a_ovf_load: assert property (overflow_load |=> status_word[2] == $past(overflow_value))
		else $error("overflow wrong");
endmodule

bind mcsr_core_regs mcsr_core_regs_chk u_chk (.*);

// ===== tb/tb_mcsr_core_regs.sv
// self-checking bench for the core special registers
`timescale 1ns/1ps
module tb_mcsr_core_regs;
	logic core_clk, reset_n, reg_wr, reg_rd, acc_load, aux_load, carry_load, carry_value;
	logic half_carry_load, half_carry_value, overflow_load, overflow_value, stack_push;
	logic stack_pop, dptr_load, dptr_inc, pointer_select;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, acc_value, aux_value, accumulator;
	logic [7:0] aux_operand, status_word, stack_top_pointer, stack_write_addr;
	logic [4:0] bank_base;
	logic [15:0] dptr_value, dptr_active;
	logic [7:0] ra [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'hF0, 8'h92, 8'hD0, 8'hE0, 8'h80};
	int n_fail, checks;
	mcsr_core_regs uut (.*);
	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(string nm, logic [15:0] v, logic [15:0] e);
		checks++;
		if (v !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, v);
		end
	endtask
	// strobe drops on the next edge, so back-to-back calls leave one idle cycle
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", reg_rdata, e);
	endtask
	// core pulses are taken at this edge, then all drop
	task automatic go;
		@(posedge core_clk);
		{acc_load, aux_load, carry_load, half_carry_load, overflow_load} <= '0;
		{stack_push, stack_pop, dptr_load, dptr_inc} <= '0;
		#1;
	endtask
	task automatic end_sim;
		if (n_fail == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		{reset_n, reg_wr, reg_rd, acc_load, aux_load, carry_load, carry_value} = '0;
		{half_carry_load, half_carry_value, overflow_load, overflow_value, stack_push} = '0;
		{stack_pop, dptr_load, dptr_inc, reg_addr, reg_wdata, acc_value, aux_value} = '0;
		dptr_value = '0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 10; i++) rd(ra[i], i == 0 ? 8'h07 : 8'h00);
		chk("waddr", stack_write_addr, 8'h08);
		for (int i = 0; i < 6; i++) wr(ra[i], 8'(8'h11 * (i + 1)));
		for (int i = 0; i < 6; i++) rd(ra[i], 8'(8'h11 * (i + 1)));
		// parity ignores status writes, the other status bits do not
		wr(8'hE0, 8'h07);
		wr(8'hD0, 8'hFE);
		rd(8'hD0, 8'hFF);
		chk("bank", bank_base, 5'h18);
		wr(8'hE0, 8'h03);
		rd(8'hD0, 8'hFE);
		wr(8'hD0, 8'h00);
		wr(8'h92, 8'hFF);
		rd(8'h92, 8'h01);
		@(posedge core_clk);
		#1 chk("dptr", dptr_active, 16'h5544);
		chk("psel", pointer_select, 1'b1);
		wr(8'h92, 8'h00);
		repeat (2) @(posedge core_clk);
		#1 chk("dptr", dptr_active, 16'h3322);
		// 16-bit load then increment carries into the high byte
		@(posedge core_clk);
		dptr_load <= 1'b1;
		dptr_value <= 16'hBEFF;
		go;
		@(posedge core_clk);
		dptr_inc <= 1'b1;
		go;
		rd(8'h82, 8'h00);
		rd(8'h83, 8'hBF);
		@(posedge core_clk);
		stack_push <= 1'b1;
		go;
		chk("waddr", stack_write_addr, 8'h13);
		@(posedge core_clk);
		stack_pop <= 1'b1;
		go;
		// flags and both operand registers in one edge
		@(posedge core_clk);
		{carry_load, carry_value, half_carry_load, half_carry_value} <= '1;
		{overflow_load, overflow_value, acc_load, aux_load} <= '1;
		acc_value <= 8'h80;
		aux_value <= 8'h3C;
		go;
		rd(8'hD0, 8'hC5);
		chk("aux", aux_operand, 8'h3C);
		// second reset in mid-run
		@(posedge core_clk);
		reset_n <= 1'b0;
		@(posedge core_clk);
		reset_n <= 1'b1;
		rd(8'h81, 8'h07);
		rd(8'hE0, 8'h00);
		end_sim;
	end
	// cut a hang short
	initial begin
		#100000;
		n_fail++;
		end_sim;
	end
endmodule
